// ==== adcr_control_regs.sv ====
// Control and result registers of the 10-bit converter, with its clock divider.
// Assumes a converter core that starts on a one-cycle pulse and answers
// with a one-cycle done pulse and a 10-bit result.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (RULE_01) Pending flag reads 0 while converting; writing 0 clears it.
// (RULE_02) Finished conversion sets pending flag; writing 1 leaves it alone.
// (RULE_03) Pending flag requests an interrupt only while interrupt enable is 1.
// (RULE_04) Clock select divides oscillator: 00 by 8, 01 by 4.
// (RULE_05) Software keeps the converter clock at or below 4 MHz.
// (RULE_06) Read-only high result register holds upper eight result bits.
// (RULE_07) Read-only low result register holds two low bits in bits 1..0.
// (RULE_08) Writing 1 to start bit converts the selected channel; 0 does nothing.
module adcr_control_regs
  import adcr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [7:0]     regAddr,
  input  wire logic [7:0]     regWrData,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic [7:0]          regRdData,
  output adcr_conv_req_t      convReq,
  input  wire adcr_conv_rsp_t convRsp,
  output logic                adcIrq
);

  // Terminal count of the divider for a clock select code
  function automatic logic [2:0] divLimit(input logic [1:0] sel);
    logic [2:0] lim;
    lim = LIM_DIV1;
    unique case (sel)
      CLK_DIV8: lim = LIM_DIV8;
      CLK_DIV4: lim = LIM_DIV4;
      CLK_DIV2: lim = LIM_DIV2;
      CLK_DIV1: lim = LIM_DIV1;
    endcase
    return lim;
  endfunction

  adcr_state_t state_q;
  logic [2:0]  chan_q;
  logic        ie_q;
  logic [1:0]  clkSel_q;
  logic        pend_q;
  logic        start_q;
  logic [2:0]  convCh_q;
  logic [2:0]  divCnt_q;
  logic        tick_q;
  logic [7:0]  resHi_q;
  logic [1:0]  resLo_q;
  logic [1:0]  irqSt_q;
  logic [1:0]  irqEn_q;
  logic [7:0]  rdData_q;
  logic        busy;
  logic        wrCtrl;
  logic        startReq;
  logic        doneEv;
  logic        pendView;
  logic [7:0]  ctrlView;

  // Decoded strobes
  assign busy     = (state_q == ST_CONV);
  assign wrCtrl   = regWr && (regAddr == ADDR_CTRL);
  assign startReq = wrCtrl && regWrData[CTRL_START]; // see RULE_08
  assign doneEv   = busy && convRsp.done;
  assign pendView = pend_q && !busy; // see RULE_01

  // Control register as software sees it; start bit reads 0
  assign ctrlView = {chan_q, ie_q, pendView, clkSel_q, 1'b0};

  // Software-written control fields
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chan_q   <= CTRL_RST[CTRL_CH_HI:CTRL_CH_LO];
      ie_q     <= CTRL_RST[CTRL_IE];
      clkSel_q <= CTRL_RST[CTRL_CLK_HI:CTRL_CLK_LO];
    end
    else if (wrCtrl)
    begin
      chan_q   <= regWrData[CTRL_CH_HI:CTRL_CH_LO];
      ie_q     <= regWrData[CTRL_IE];
      clkSel_q <= regWrData[CTRL_CLK_HI:CTRL_CLK_LO];
    end
  end

  // Pending flag: done sets, written 0 clears, set wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pend_q <= CTRL_RST[CTRL_EOC];
    else if (doneEv)
      pend_q <= 1'b1; // see RULE_02
    else if (wrCtrl && !regWrData[CTRL_EOC])
      pend_q <= 1'b0; // see RULE_01
  end

  // Conversion sequencer; a start while busy is dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE: if (startReq) state_q <= ST_CONV; // see RULE_08
        ST_CONV: if (convRsp.done) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Start pulse and channel held for the converter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_q  <= 1'b0;
      convCh_q <= CTRL_RST[CTRL_CH_HI:CTRL_CH_LO];
    end
    else
    begin
      start_q <= startReq && !busy; // see RULE_08
      if (startReq && !busy)
        convCh_q <= regWrData[CTRL_CH_HI:CTRL_CH_LO];
    end
  end

  // Converter clock divider, one tick per divided period
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      divCnt_q <= CNT_ZERO;
      tick_q   <= 1'b0;
    end
    else
    begin
      if (divCnt_q >= divLimit(clkSel_q)) // see RULE_04
        divCnt_q <= CNT_ZERO;
      else
        divCnt_q <= divCnt_q + 3'h1;
      tick_q <= (divCnt_q >= divLimit(clkSel_q));
    end
  end

  // Result capture at the end of a conversion
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resHi_q <= RES_RST[9:2];
      resLo_q <= RES_RST[1:0];
    end
    else if (doneEv)
    begin
      resHi_q <= convRsp.result[9:2]; // see RULE_06
      resLo_q <= convRsp.result[1:0]; // see RULE_07
    end
  end

  // Sticky interrupt status, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irqSt_q <= IRQ_RST;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_DONE && doneEv) || (i == IRQ_OVERRUN && startReq && busy))
          irqSt_q[i] <= 1'b1;
        else if (regWr && regAddr == ADDR_IRQ_CLR && regWrData[i])
          irqSt_q[i] <= 1'b0;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irqEn_q <= IRQ_RST;
    else if (regWr && regAddr == ADDR_IRQ_EN)
      irqEn_q <= regWrData[1:0];
  end

  // Read data one cycle after the strobe; unmapped reads give 0
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData_q <= 8'h00;
    else if (regRd)
    begin
      unique case (regAddr)
        ADDR_RES_HI: rdData_q <= resHi_q; // see RULE_06
        ADDR_RES_LO: rdData_q <= {6'h00, resLo_q}; // see RULE_07
        ADDR_CTRL:   rdData_q <= ctrlView;
        ADDR_IRQ_ST: rdData_q <= {6'h00, irqSt_q};
        ADDR_IRQ_EN: rdData_q <= {6'h00, irqEn_q};
        default:     rdData_q <= 8'h00;
      endcase
    end
    else
      rdData_q <= 8'h00;
  end

  // Outputs
  // The request struct has a single driver, so its fields never compete
  assign regRdData       = rdData_q;
  assign convReq         = '{start: start_q, channel: convCh_q, clkTick: tick_q};
  assign adcIrq = (pendView && ie_q) || (|(irqSt_q & irqEn_q)); // see RULE_03

  // Pending reads 0 while converting
  property p_pend_hidden;
    @(posedge clk) disable iff (!rst_n)
    (busy && regRd && regAddr == ADDR_CTRL) |=> !regRdData[CTRL_EOC];
  endproperty
  a_pend_hidden: assert property (p_pend_hidden) // see RULE_01
    else $error("pending flag visible during conversion");

  // Writing 0 clears the flag unless a conversion ends
  property p_pend_clear;
    @(posedge clk) disable iff (!rst_n)
    (wrCtrl && !regWrData[CTRL_EOC] && !doneEv) |=> !pend_q;
  endproperty
  a_pend_clear: assert property (p_pend_clear) // see RULE_01
    else $error("pending flag not cleared by write of 0");

  // End of conversion sets the flag, also against a clear
  property p_pend_set;
    @(posedge clk) disable iff (!rst_n)
    doneEv |=> pend_q;
  endproperty
  a_pend_set: assert property (p_pend_set) // see RULE_02
    else $error("pending flag not set at end of conversion");

  // Writing 1 keeps the flag
  property p_pend_keep;
    @(posedge clk) disable iff (!rst_n)
    (wrCtrl && regWrData[CTRL_EOC] && pend_q) |=> pend_q;
  endproperty
  a_pend_keep: assert property (p_pend_keep) // see RULE_02
    else $error("write of 1 disturbed pending flag");

  // Interrupt follows the visible flag and its enable
  property p_irq;
    @(posedge clk) disable iff (!rst_n)
    (irqSt_q == IRQ_RST) |-> (adcIrq == (pendView && ie_q));
  endproperty
  a_irq: assert property (p_irq) // see RULE_03
    else $error("converter interrupt does not follow flag and enable");

  // Divide by 4 gives a tick every fourth cycle
  property p_div4;
    @(posedge clk) disable iff (!rst_n)
    (tick_q && clkSel_q == CLK_DIV4) ##1 (clkSel_q == CLK_DIV4)[*3]
      |-> !tick_q ##1 tick_q;
  endproperty
  a_div4: assert property (p_div4) // see RULE_04
    else $error("divide by 4 tick spacing wrong");

  // Divide by 8 gives a tick every eighth cycle
  property p_div8;
    @(posedge clk) disable iff (!rst_n)
    (tick_q && clkSel_q == CLK_DIV8) ##1 (clkSel_q == CLK_DIV8)[*7]
      |-> !tick_q ##1 tick_q;
  endproperty
  a_div8: assert property (p_div8) // see RULE_04
    else $error("divide by 8 tick spacing wrong");

  // Upper result bits are captured at the end of a conversion
  property p_res_hi;
    @(posedge clk) disable iff (!rst_n)
    doneEv |=> (resHi_q == $past(convRsp.result[9:2]));
  endproperty
  a_res_hi: assert property (p_res_hi) // see RULE_06
    else $error("upper result bits not captured");

  // Low result register keeps its upper six bits at zero
  property p_res_lo;
    @(posedge clk) disable iff (!rst_n)
    (regRd && regAddr == ADDR_RES_LO)
      |=> (regRdData == {6'h00, $past(resLo_q)});
  endproperty
  a_res_lo: assert property (p_res_lo) // see RULE_07
    else $error("low result register read wrong");

  // Start from idle issues one pulse with the written channel
  property p_start;
    @(posedge clk) disable iff (!rst_n)
    (startReq && !busy)
      |=> (convReq.start && convReq.channel == $past(regWrData[CTRL_CH_HI:CTRL_CH_LO]))
      ##1 !convReq.start;
  endproperty
  a_start: assert property (p_start) // see RULE_08
    else $error("start pulse or channel wrong");

  // Writing 0 to the start bit never starts
  property p_nostart;
    @(posedge clk) disable iff (!rst_n)
    (!startReq) |=> !convReq.start;
  endproperty
  a_nostart: assert property (p_nostart) // see RULE_08
    else $error("conversion started without start bit");

  // A start while converting is dropped but flagged as overrun
  property p_overrun;
    @(posedge clk) disable iff (!rst_n)
    (startReq && busy) |=> irqSt_q[IRQ_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) // see RULE_08
    else $error("start during conversion not flagged as overrun");

  // Writing 1 to the clear register drops the done status bit
  property p_irq_clear;
    @(posedge clk) disable iff (!rst_n)
    (regWr && regAddr == ADDR_IRQ_CLR && regWrData[IRQ_DONE] && !doneEv) |=> !irqSt_q[IRQ_DONE];
  endproperty
  a_irq_clear: assert property (p_irq_clear) // see RULE_03
    else $error("done status bit not cleared");

  // Once a conversion ends the pending flag is visible to software
  property p_pend_visible;
    @(posedge clk) disable iff (!rst_n)
    doneEv |=> pendView;
  endproperty
  a_pend_visible: assert property (p_pend_visible) // see RULE_02
    else $error("pending flag hidden after conversion end");

  // Divide by 2 gives a tick every second cycle
  property p_div2;
    @(posedge clk) disable iff (!rst_n)
    (tick_q && clkSel_q == CLK_DIV2) ##1 (clkSel_q == CLK_DIV2)
      |-> !tick_q ##1 tick_q;
  endproperty
  a_div2: assert property (p_div2) // see RULE_04
    else $error("divide by 2 tick spacing wrong");

endmodule

`default_nettype wire

// ==== adcr_pkg.sv ====
// Constants and carriers for the converter control and result registers.
// Assumes an 8-bit register port and an external converter core.
package adcr_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_RES_HI  = 8'hF8;
  localparam logic [7:0] ADDR_RES_LO  = 8'hF9;
  localparam logic [7:0] ADDR_CTRL    = 8'hFA;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'hFB;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'hFC;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'hFE;
  // Control register fields
  localparam int CTRL_CH_HI  = 7;
  localparam int CTRL_CH_LO  = 5;
  localparam int CTRL_IE     = 4;
  localparam int CTRL_EOC    = 3;
  localparam int CTRL_CLK_HI = 2;
  localparam int CTRL_CLK_LO = 1;
  localparam int CTRL_START  = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [1:0] IRQ_RST   = 2'h0;
  localparam logic [9:0] RES_RST   = 10'h000;
  // Interrupt status bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_OVERRUN = 1;
  // Clock select codes and divider terminal counts
  localparam logic [1:0] CLK_DIV8 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV2 = 2'h2;
  localparam logic [1:0] CLK_DIV1 = 2'h3;
  localparam logic [2:0] LIM_DIV8 = 3'h7;
  localparam logic [2:0] LIM_DIV4 = 3'h3;
  localparam logic [2:0] LIM_DIV2 = 3'h1;
  localparam logic [2:0] LIM_DIV1 = 3'h0;
  localparam logic [2:0] CNT_ZERO = 3'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcr_state_t;

  // Request toward the converter core
  typedef struct packed {
    logic       start;
    logic [2:0] channel;
    logic       clkTick;
  } adcr_conv_req_t;

  // Answer from the converter core
  typedef struct packed {
    logic       done;
    logic [9:0] result;
  } adcr_conv_rsp_t;
endpackage

// ==== adcr_conv_model.sv ====
// Behavioural converter core seen from the control block.
// Assumes start, channel and clkTick come from adcr_control_regs.
`timescale 1ns/1ps
`default_nettype none
module adcr_conv_model
  import adcr_pkg::*;
#(
  parameter int TICKS = 12
)
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire adcr_conv_req_t convReq,
  output adcr_conv_rsp_t      convRsp
);
  logic       busy_q;
  logic       done_q;
  logic [4:0] cnt_q;
  logic [9:0] val_q;

  // Converts for TICKS converter ticks, then pulses done with a channel-coded result
  always_ff @(posedge clk)
  begin
    done_q <= 1'b0;
    if (!rst_n)
      busy_q <= 1'b0;
    else if (convReq.start)
    begin
      busy_q <= 1'b1;
      cnt_q  <= 5'h00;
      val_q  <= {convReq.channel, 7'h2B};
    end
    else if (busy_q && convReq.clkTick)
    begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == 5'(TICKS - 1))
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  // Result lines are only valid with done; otherwise they show the inverse
  assign convRsp = {done_q, done_q ? val_q : ~val_q};
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the converter control registers.
// Assumes adcr_conv_model stands in for the converter core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top
  import adcr_pkg::*;
;
  logic           clk;
  logic           rst_n;
  logic [7:0]     regAddr;
  logic [7:0]     regWrData;
  logic           regWr;
  logic           regRd;
  logic [7:0]     regRdData;
  logic           adcIrq;
  adcr_conv_req_t convReq;
  adcr_conv_rsp_t convRsp;
  int             miscompares;
  int             samples_checked;

  adcr_control_regs dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .convReq(convReq), .convRsp(convRsp),
    .adcIrq(adcIrq));
  adcr_conv_model model_u (.clk(clk), .rst_n(rst_n), .convReq(convReq), .convRsp(convRsp));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read, data sampled in the following cycle
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask

  // Bounded wait for the core's done pulse
  task automatic wait_done;
    int n;
    n = 0;
    while (convRsp.done !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 2000)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (convReq.clkTick !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic t_reset;
    chk_rd(ADDR_CTRL, CTRL_RST);
    chk_rd(ADDR_IRQ_ST, 8'h00);
    chk_rd(8'h10, 8'h00);
    `CHK(adcIrq, 1'b0)
    $display("reset test done");
  endtask

  // Every channel code, with results split over the two result registers
  task automatic t_conv;
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(ADDR_CTRL, {3'(ch), 5'h01});
      #1 `CHK(convReq.start, 1'b1)
      `CHK(convReq.channel, 3'(ch))
      chk_rd(ADDR_CTRL, {3'(ch), 5'h00});
      wait_done();
      chk_rd(ADDR_CTRL, {3'(ch), 5'h08});
      chk_rd(ADDR_RES_HI, {3'(ch), 5'h0A});
      chk_rd(ADDR_RES_LO, 8'h03);
    end
    wr(ADDR_CTRL, 8'h00);
    #1 `CHK(convReq.start, 1'b0)
    $display("conversion test done");
  endtask

  // Tick spacing for every clock select code: 8, 4, 2 and 1 cycles
  task automatic t_clock;
    int n;
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CTRL, {5'h00, 2'(s), 1'b0});
      wait_tick(n);
      wait_tick(n);
      `CHK(n, 8 >> s)
    end
    $display("clock test done");
  endtask

  // Overrun, status, enable, clear and pending flag behaviour
  task automatic t_irq;
    wr(ADDR_IRQ_CLR, 8'h03);
    chk_rd(ADDR_IRQ_ST, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    chk_rd(ADDR_IRQ_ST, 8'h02);
    wait_done();
    chk_rd(ADDR_IRQ_ST, 8'h03);
    `CHK(adcIrq, 1'b0)
    wr(ADDR_IRQ_EN, 8'h02);
    #1 `CHK(adcIrq, 1'b1)
    wr(ADDR_IRQ_CLR, 8'h02);
    #1 `CHK(adcIrq, 1'b0)
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    #1 `CHK(adcIrq, 1'b1)
    wr(ADDR_CTRL, 8'h08);
    #1 `CHK(adcIrq, 1'b0)
    chk_rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    chk_rd(ADDR_CTRL, 8'h00);
    wr(ADDR_RES_HI, 8'hFF);
    chk_rd(ADDR_RES_HI, 8'h0A);
    $display("interrupt test done");
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    clk             = 1'b0;
    rst_n           = 1'b0;
    regAddr         = 8'h00;
    regWrData       = 8'h00;
    regWr           = 1'b0;
    regRd           = 1'b0;
    miscompares     = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_clock();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
